/* File: ddr_capture_consts.svh */
// constants for the double-data-rate read capture block
`ifndef DDR_CAPTURE_CONSTS_SVH
`define DDR_CAPTURE_CONSTS_SVH

// width of the read data bus on the pins
`define DDR_DQ_WIDTH 8
// depth of the pair FIFO and its address width
`define DDR_FIFO_DEPTH 4
`define DDR_FIFO_AW 2
// reset value of every capture and synchronizing register
`define DDR_DATA_RST 8'h00
// cycles from a sampled rising edge to the FIFO write
`define DDR_PIPE_LAT 3

`endif

/* File: ddr_capture_pkg.sv */
// types shared by the double-data-rate read capture block
`include "ddr_capture_consts.svh"

package ddr_capture_pkg;

   // one sample of the read data bus
   typedef logic [`DDR_DQ_WIDTH-1:0] dq_word_t;

   // one captured pair: high phase from the rising edge, low phase from the falling edge
   typedef struct packed
   {
      dq_word_t hi;
      dq_word_t lo;
   } dq_pair_t;

   // FIFO pointer with one wrap bit
   typedef logic [`DDR_FIFO_AW:0] fifo_ptr_t;

endpackage

/* File: ddr_mem_model.sv */
// behavioural external memory driving double-data-rate read data
`timescale 1ns/100ps
`default_nettype none

// ************
// memory model
// ************
module ddr_mem_model
   import ddr_capture_pkg::*;
(
   input wire logic core_clk,
   input wire logic burst_en,
   input wire dq_word_t hi_w,
   input wire dq_word_t lo_w,
   output var dq_word_t dq_pin
);
   dq_word_t lo_hold = 8'h00;
   logic en_hold = 1'b0;
   dq_word_t dq_r = 8'h00;
   assign dq_pin = dq_r;
   // one process drives the pins; no read strobe is driven
   // high word launched after the falling edge, low word after the rising edge
   always @(core_clk)
   begin
      if (core_clk)
      begin
         lo_hold = lo_w;
         en_hold = burst_en;
         #6;
         dq_r = en_hold ? lo_hold : ~dq_r; // released bus toggles
      end
      else
      begin
         #6;
         dq_r = burst_en ? hi_w : ~dq_r; // released bus toggles
      end
   end
endmodule
`default_nettype wire

/* File: ddr_read_data_capture.sv */
// double-data-rate read data capture into paired single-rate words
`timescale 1ns/100ps
`default_nettype none
`include "ddr_capture_consts.svh"

module ddr_read_data_capture
   import ddr_capture_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire dq_word_t dq_pin,
   input wire logic rd_window,
   input wire logic pair_ready,
   output logic pair_valid,
   output var dq_pair_t pair_data,
   output logic overflow_r
);

   // ************************************************************
   // helpers
   // ************************************************************

   // pointer advance, used by both FIFO ends
   function automatic fifo_ptr_t ptr_inc(input fifo_ptr_t p);
      ptr_inc = fifo_ptr_t'(p + 1'b1);
   endfunction

   // ************************************************************
   // edge capture
   // ************************************************************

   // core_clk is the PLL read-capture clock; no strobe input exists at all
   dq_word_t rise_r;
   dq_word_t fall_r;
   dq_word_t rise_hold_r;
   dq_word_t align_r;
   dq_word_t sync_h_r;
   dq_word_t sync_l_r;
   logic [`DDR_PIPE_LAT-1:0] win_pipe_r;

   // rising-edge capture of every data bit
   always_ff @(posedge core_clk)
   begin
      if (srst)
         rise_r <= `DDR_DATA_RST;
      else
         rise_r <= dq_pin;
   end

   // falling-edge capture of the same bits
   always_ff @(negedge core_clk)
   begin
      if (srst)
         fall_r <= `DDR_DATA_RST;
      else
         fall_r <= dq_pin;
   end

   // ************************************************************
   // alignment and synchronizing stage
   // ************************************************************

   // bring the falling sample onto the rising edge beside its rising partner
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rise_hold_r <= `DDR_DATA_RST;
         align_r <= `DDR_DATA_RST;
      end
      else
      begin
         rise_hold_r <= rise_r;
         align_r <= fall_r;
      end
   end

   // high and low synchronizing registers
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         sync_h_r <= `DDR_DATA_RST;
         sync_l_r <= `DDR_DATA_RST;
      end
      else
      begin
         sync_h_r <= rise_hold_r;
         sync_l_r <= align_r;
      end
   end

   // read window follows the data through the same stages
   always_ff @(posedge core_clk)
   begin
      if (srst)
         win_pipe_r <= '0;
      else
         win_pipe_r <= {win_pipe_r[`DDR_PIPE_LAT-2:0], rd_window};
   end

   // ************************************************************
   // pair FIFO
   // ************************************************************

   dq_pair_t mem [`DDR_FIFO_DEPTH];
   fifo_ptr_t wr_ptr_r;
   fifo_ptr_t rd_ptr_r;
   logic fifo_full;
   logic fifo_empty;
   logic wr_en;
   logic rd_en;

   // full and empty from wrap-bit pointers
   assign fifo_empty = (wr_ptr_r == rd_ptr_r);
   assign fifo_full = (wr_ptr_r[`DDR_FIFO_AW] != rd_ptr_r[`DDR_FIFO_AW]) &&
                      (wr_ptr_r[`DDR_FIFO_AW-1:0] == rd_ptr_r[`DDR_FIFO_AW-1:0]);
   assign wr_en = win_pipe_r[`DDR_PIPE_LAT-1] && !fifo_full;
   assign rd_en = pair_valid && pair_ready;

   // storage: one entry holds both phases of one capture
   always_ff @(posedge core_clk)
   begin
      if (wr_en)
         mem[wr_ptr_r[`DDR_FIFO_AW-1:0]] <= '{hi: sync_h_r, lo: sync_l_r};
   end

   // write pointer
   always_ff @(posedge core_clk)
   begin
      if (srst)
         wr_ptr_r <= '0;
      else if (wr_en)
         wr_ptr_r <= ptr_inc(wr_ptr_r);
   end

   // read pointer, strict first-in first-out order
   always_ff @(posedge core_clk)
   begin
      if (srst)
         rd_ptr_r <= '0;
      else if (rd_en)
         rd_ptr_r <= ptr_inc(rd_ptr_r);
   end

   // sticky overflow when a pair arrives with the FIFO full
   always_ff @(posedge core_clk)
   begin
      if (srst)
         overflow_r <= 1'b0;
      else if (win_pipe_r[`DDR_PIPE_LAT-1] && fifo_full)
         overflow_r <= 1'b1;
   end

   // output side: both phases presented in the same cycle
   assign pair_valid = !fifo_empty;
   assign pair_data = fifo_empty ? dq_pair_t'('0) : mem[rd_ptr_r[`DDR_FIFO_AW-1:0]];

   // ************************************************************
   // assertions
   // ************************************************************

   fifo_ptr_t fill;
   assign fill = fifo_ptr_t'(wr_ptr_r - rd_ptr_r);

   AST_RISE_SAMPLE: assert property (@(posedge core_clk) disable iff (srst)
      !$past(srst) |-> rise_r == $past(dq_pin))
      else $error("rise register missed the rising-edge sample");

   AST_FALL_SAMPLE: assert property (@(negedge core_clk) disable iff (srst)
      !$past(srst) |-> fall_r == $past(dq_pin))
      else $error("fall register missed the falling-edge sample");

   AST_ALIGN: assert property (@(posedge core_clk) disable iff (srst)
      !$past(srst) |-> align_r == $past(fall_r))
      else $error("alignment register did not retime the fall sample");

   AST_SYNC_HI: assert property (@(posedge core_clk) disable iff (srst)
      !$past(srst, 3) && !$past(srst, 2) && !$past(srst) |-> sync_h_r == $past(dq_pin, 3))
      else $error("high sync register not three cycles after pin");

   AST_SYNC_LO: assert property (@(posedge core_clk) disable iff (srst)
      !$past(srst, 2) && !$past(srst) |-> sync_l_r == $past(fall_r, 2))
      else $error("low sync register not aligned with fall sample");

   AST_WRITE_LAT: assert property (@(posedge core_clk) disable iff (srst)
      rd_window && !pair_valid && win_pipe_r == '0 |-> !pair_valid [*4] ##1 pair_valid)
      else $error("captured pair did not reach the FIFO in time");

   AST_FULL_DROP: assert property (@(posedge core_clk) disable iff (srst)
      win_pipe_r[`DDR_PIPE_LAT-1] && fifo_full |=> $stable(wr_ptr_r))
      else $error("pair written into a full FIFO");

   AST_PAIR_HOLD: assert property (@(posedge core_clk) disable iff (srst)
      pair_valid && !pair_ready |=> pair_valid && $stable(pair_data))
      else $error("pair changed while stalled");

   AST_NO_OVERRUN: assert property (@(posedge core_clk) disable iff (srst)
      fill <= 3'(`DDR_FIFO_DEPTH))
      else $error("FIFO fill exceeds its depth");

   AST_OVF_STICKY: assert property (@(posedge core_clk) disable iff (srst)
      win_pipe_r[`DDR_PIPE_LAT-1] && fifo_full |=> overflow_r [*2])
      else $error("overflow flag not set and held");

   COV_PAIR_OUT: cover property (@(posedge core_clk) disable iff (srst) rd_en);
   COV_FULL: cover property (@(posedge core_clk) disable iff (srst) fifo_full);
   COV_STALL: cover property (@(posedge core_clk) disable iff (srst) (pair_valid && !pair_ready) [*3]);
   COV_OVF: cover property (@(posedge core_clk) disable iff (srst) $rose(overflow_r));

endmodule

`default_nettype wire

/* File: ddr_read_data_capture_tb.sv */
// self-checking bench for the double-data-rate read capture block
`timescale 1ns/100ps
`default_nettype none

// *********
// testbench
// *********
module ddr_read_data_capture_tb;
   import ddr_capture_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic rd_window = 1'b0;
   logic pair_ready = 1'b0;
   logic burst_en = 1'b0;
   dq_word_t hi_w = 8'h00;
   dq_word_t lo_w = 8'h00;
   dq_word_t dq_pin;
   logic pair_valid;
   dq_pair_t pair_data;
   logic overflow_r;
   dq_pair_t exp_q[$];
   int err_count = 0;
   int n_tests = 0;
   int r;
   always #12.5 core_clk = ~core_clk;
   ddr_mem_model mem_u (.core_clk(core_clk), .burst_en(burst_en), .hi_w(hi_w), .lo_w(lo_w), .dq_pin(dq_pin));
   ddr_read_data_capture dut_u (.core_clk(core_clk), .srst(srst), .dq_pin(dq_pin), .rd_window(rd_window),
      .pair_ready(pair_ready), .pair_valid(pair_valid), .pair_data(pair_data), .overflow_r(overflow_r));
   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // one cycle of stimulus at the falling edge; a pair expected out is noted
   task automatic beat(input logic keep, input logic note, input logic rdy);
      @(negedge core_clk);
      hi_w = dq_word_t'($urandom);
      lo_w = dq_word_t'($urandom);
      burst_en = keep;
      rd_window = keep;
      pair_ready = rdy;
      if (note)
         exp_q.push_back({hi_w, lo_w});
   endtask
   // pop the oldest note whenever a pair is taken
   always @(posedge core_clk)
      if (!srst && pair_valid === 1'b1 && pair_ready)
      begin
         if (exp_q.size() == 0)
            check(16'h0001, 16'h0000);
         else
            check(pair_data, exp_q.pop_front());
      end
   initial
   begin
      #(25 * 2000);
      err_count++;
      report_and_stop();
   end
   initial
   begin
      void'($urandom(32'h9EF26762));
      repeat (16) @(posedge core_clk);
      @(negedge core_clk);
      srst <= 1'b0;
      check(pair_data, 16'h0000);
      check({14'h0000, pair_valid, overflow_r}, 16'h0000);
      $display("test reset done");
      // one pair, then idle cycles with the window closed
      beat(1'b1, 1'b1, 1'b0);
      repeat (3) beat(1'b0, 1'b0, 1'b0);
      check({15'h0000, pair_valid}, 16'h0000);
      beat(1'b0, 1'b0, 1'b0);
      check({15'h0000, pair_valid}, 16'h0001);
      beat(1'b0, 1'b0, 1'b0);
      check({15'h0000, pair_valid}, 16'h0001);
      $display("test latency done");
      repeat (300)
      begin
         r = $urandom % 2;
         beat(r[0], r[0], 1'b1);
      end
      repeat (6) beat(1'b0, 1'b0, 1'b1);
      check(16'(exp_q.size()), 16'h0000);
      $display("test stream done");
      for (int i = 0; i < 5; i++)
         beat(1'b1, i < 4, 1'b0);
      repeat (4) beat(1'b0, 1'b0, 1'b0);
      check({15'h0000, overflow_r}, 16'h0001);
      repeat (8) beat(1'b0, 1'b0, 1'b1);
      check({15'h0000, overflow_r}, 16'h0001);
      check(16'(exp_q.size()), 16'h0000);
      $display("test overflow done");
      srst <= 1'b1;
      repeat (2) @(negedge core_clk);
      srst <= 1'b0;
      check({14'h0000, pair_valid, overflow_r}, 16'h0000);
      // capture works again right after the mid-run reset
      beat(1'b1, 1'b1, 1'b1);
      repeat (5) beat(1'b0, 1'b0, 1'b1);
      check(16'(exp_q.size()), 16'h0000);
      $display("test second reset done");
      report_and_stop();
   end
endmodule
`default_nettype wire
